// File: dpll_pkg.sv
// constants, register map and types shared by the reference select and status block
package dpll_pkg;

	localparam int CLK_HZ         = 40_000_000;
	localparam int CLK_PERIOD_NS  = 25;
	localparam int FRAME_NS       = 125_000;
	localparam int FRAME_CYCLES   = FRAME_NS / CLK_PERIOD_NS;
	localparam int SECOND_NS      = 1_000_000_000;
	localparam int SECOND_CYCLES  = SECOND_NS / CLK_PERIOD_NS;
	localparam int CLEAR_MIN_NS   = 300;
	localparam int CLEAR_MIN_CYC  = (CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int REF_NOMINAL_HZ = 19_440_000;
	localparam int RANGE_PPM      = 12;
	localparam int REF_TOL_EDGES  = int'((64'(REF_NOMINAL_HZ) * RANGE_PPM) / 1_000_000);
	localparam int CNT_W          = 26;
	localparam int PHASE_W        = 13;

	localparam int LOCK_FRAMES      = 64;
	localparam int FAST_LOCK_FRAMES = 8;
	localparam int ACQ_W            = 7;
	localparam int QUARTER_DIV      = 4;

	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_OFS       = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFS     = 8'h04;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFS   = 8'h0c;
	localparam logic [ADDR_W-1:0] MAIN_COUNT_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] ALT_COUNT_OFS  = 8'h14;
	localparam logic [ADDR_W-1:0] TIE_OFFSET_OFS = 8'h18;

	localparam int CTRL_REF_SEL_BIT   = 0;
	localparam int CTRL_E3_MODE_BIT   = 1;
	localparam int CTRL_FULL_RATE_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h4;

	localparam int IRQ_W             = 5;
	localparam int IRQ_LOCK_GAIN_BIT = 0;
	localparam int IRQ_LOCK_LOSS_BIT = 1;
	localparam int IRQ_HOLD_BIT      = 2;
	localparam int IRQ_MAIN_OOR_BIT  = 3;
	localparam int IRQ_ALT_OOR_BIT   = 4;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		ST_FREERUN  = 4'h1,
		ST_ACQUIRE  = 4'h2,
		ST_NORMAL   = 4'h4,
		ST_HOLDOVER = 4'h8
	} loop_state_t;

endpackage

// File: timing_if.sv
// timing and reference measurement signals between the core and its helpers
`timescale 1ns/10ps
interface timing_if;
	logic                                 frameTick;
	logic                                 secondTick;
	logic [dpll_pkg::PHASE_W-1:0]         phase;
	logic [1:0]                           refIn;
	logic [1:0]                           oor;
	logic [1:0]                           valid;
	logic [1:0][dpll_pkg::CNT_W-1:0]      count;

	modport timer (output frameTick, output secondTick, output phase);
	modport monitor (input secondTick, input refIn, output oor, output valid, output count);
	modport core (input frameTick, input secondTick, input phase, input oor, input valid,
		input count, output refIn);
endinterface

// File: frame_timer.sv
// 8 kHz frame tick, frame phase and one second gate derived from mclk
`timescale 1ns/10ps
module frame_timer #(
	parameter int FRAME_CYCLES  = dpll_pkg::FRAME_CYCLES,
	parameter int SECOND_CYCLES = dpll_pkg::SECOND_CYCLES
) (
	input  wire logic   mclk,
	input  wire logic   arst_n,
	timing_if.timer     tif
);
	logic [dpll_pkg::PHASE_W-1:0] phase_reg;
	logic [dpll_pkg::CNT_W-1:0]   second_reg;
	logic                         frame_reg;
	logic                         secTick_reg;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			phase_reg <= '0;
			frame_reg <= 1'b0;
		end else if (phase_reg == dpll_pkg::PHASE_W'(FRAME_CYCLES - 1)) begin
			phase_reg <= '0;
			frame_reg <= 1'b1;
		end else begin
			phase_reg <= phase_reg + 1'b1;
			frame_reg <= 1'b0;
		end
	end

	// gate for the frequency measurement, from the master clock only
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			second_reg  <= '0;
			secTick_reg <= 1'b0;
		end else if (second_reg == dpll_pkg::CNT_W'(SECOND_CYCLES - 1)) begin // R14 R15
			second_reg  <= '0;
			secTick_reg <= 1'b1;
		end else begin
			second_reg  <= second_reg + 1'b1;
			secTick_reg <= 1'b0;
		end
	end

	assign tif.frameTick  = frame_reg;
	assign tif.secondTick = secTick_reg;
	assign tif.phase      = phase_reg;
endmodule

// File: freq_monitor.sv
// per reference edge counter and out of range check over the one second gate
`timescale 1ns/10ps
module freq_monitor (
	input  wire logic   mclk,
	input  wire logic   arst_n,
	timing_if.monitor   tif
);
	localparam logic signed [dpll_pkg::CNT_W:0] NOMINAL =
		(dpll_pkg::CNT_W+1)'(dpll_pkg::REF_NOMINAL_HZ);
	localparam logic signed [dpll_pkg::CNT_W:0] TOL =
		(dpll_pkg::CNT_W+1)'(dpll_pkg::REF_TOL_EDGES);

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			logic                          prev_reg;
			logic [dpll_pkg::CNT_W-1:0]    edges_reg;
			logic [dpll_pkg::CNT_W-1:0]    count_reg;
			logic                          oor_reg;
			logic                          valid_reg;
			logic                          riseNow;
			logic [dpll_pkg::CNT_W-1:0]    total;
			logic signed [dpll_pkg::CNT_W:0] diff;

			assign riseNow = tif.refIn[ch] & ~prev_reg;
			assign total   = edges_reg + dpll_pkg::CNT_W'(riseNow);
			assign diff    = $signed({1'b0, total}) - NOMINAL;

			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					prev_reg  <= 1'b0;
					edges_reg <= '0;
					count_reg <= '0;
					oor_reg   <= 1'b0;
					valid_reg <= 1'b0;
				end else begin
					prev_reg <= tif.refIn[ch];
					if (tif.secondTick) begin
						edges_reg <= '0;
						count_reg <= total;
						oor_reg   <= (diff > TOL) || (diff < -TOL); // R13 R17
						valid_reg <= 1'b1;
					end else begin
						edges_reg <= total;
					end
				end
			end

			assign tif.oor[ch]   = oor_reg;
			assign tif.valid[ch] = valid_reg;
			assign tif.count[ch] = count_reg;
		end
	endgenerate
endmodule

// File: dpll_ref_select_and_status.sv
// reference select, error corrector control, output rate and status with register slave
`timescale 1ns/10ps
// Operation
// R1: select low primary, high secondary reference
// R2: sample select at frame tick rising edge
// R3: low clear resets error corrector offset
// R4: clear held low 300 ns minimum
// R5: corrector disabled while clear stays low
// R6: rate select high full, low quarter
// R7: pins in hardware mode, bits otherwise
// R8: holdover output high in holdover state
// R9: lock output high while frequency locked
// R10: continuity control gates holdover to normal
// R11: sample continuity control at frame tick
// R12: fast acquire only in hardware mode
// R13: secondary beyond 12 ppm flags out of range
// R14: range check over one second gate
// R15: all timing from master clock
// R16: mode select low bus, high pins
// R17: primary beyond 12 ppm flags out of range
// R18: frame tick every 125 us, internally made
module dpll_ref_select_and_status #(
	parameter int FRAME_CYCLES  = dpll_pkg::FRAME_CYCLES,
	parameter int SECOND_CYCLES = dpll_pkg::SECOND_CYCLES
) (
	input  wire logic                          mclk,
	input  wire logic                          arst_n,
	input  wire logic [dpll_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [dpll_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          primaryRefInput,
	input  wire logic                          secondaryRefInput,
	input  wire logic                          refSourceSelect,
	input  wire logic                          phaseErrorClearN,
	input  wire logic                          e3Ds3ModePin,
	input  wire logic                          e3Ds3FullRateSelect,
	input  wire logic                          phaseContinuityCtl,
	input  wire logic                          fastAcquireRequest,
	input  wire logic                          pinControlModeSelect,
	output logic                               frame8kTick,
	output logic                               e3Ds3ClockOut,
	output logic                               e3Ds3Mode,
	output logic                               holdover,
	output logic                               lock,
	output logic                               primaryOutOfRange,
	output logic                               secondaryOutOfRange,
	output logic                               tieCorrectEnable,
	output logic                               irq
);
	timing_if tif ();

	frame_timer #(
		.FRAME_CYCLES  (FRAME_CYCLES),
		.SECOND_CYCLES (SECOND_CYCLES)
	) u_timer (
		.mclk   (mclk),
		.arst_n (arst_n),
		.tif    (tif.timer)
	);

	freq_monitor u_mon (
		.mclk   (mclk),
		.arst_n (arst_n),
		.tif    (tif.monitor)
	);

	logic [2:0]                     ctrl_reg;
	logic [dpll_pkg::IRQ_W-1:0]     irqStatus_reg;
	logic [dpll_pkg::IRQ_W-1:0]     irqMask_reg;
	logic [1:0]                     refIn_reg;
	logic                           refSel_reg;
	logic                           pcc_reg;
	logic                           clearN_reg;
	dpll_pkg::loop_state_t          state_reg;
	dpll_pkg::loop_state_t          state_next;
	logic [dpll_pkg::ACQ_W-1:0]     acq_reg;
	logic [dpll_pkg::PHASE_W-1:0]   tieOffset_reg;
	logic [1:0]                     div_reg;
	logic                           lockPrev_reg;
	logic                           holdPrev_reg;
	logic [1:0]                     oorPrev_reg;
	logic                           awGot_reg;
	logic                           wGot_reg;
	logic [dpll_pkg::ADDR_W-1:0]    awAddr_reg;
	logic [31:0]                    wData_reg;
	logic [3:0]                     wStrb_reg;

	logic                           pinMode;
	logic                           refSelNow;
	logic                           fullRate;
	logic                           fastAcq;
	logic                           refGood;
	logic [dpll_pkg::ACQ_W-1:0]     acqTarget;
	logic                           writeFire;
	logic                           awGot_next;
	logic                           wGot_next;
	logic                           readFire;
	logic                           statusRead;
	logic [dpll_pkg::IRQ_W-1:0]     events;
	logic [31:0]                    readMux;
	logic                           readHit;
	logic                           writeHit;

	// mode, select and option resolution
	assign pinMode   = pinControlModeSelect; // R16
	assign refSelNow = pinMode ? refSourceSelect
		: ctrl_reg[dpll_pkg::CTRL_REF_SEL_BIT]; // R7
	assign fullRate  = pinMode ? e3Ds3FullRateSelect
		: ctrl_reg[dpll_pkg::CTRL_FULL_RATE_BIT]; // R7
	assign fastAcq   = pinMode & fastAcquireRequest; // R12
	assign acqTarget = fastAcq ? dpll_pkg::ACQ_W'(dpll_pkg::FAST_LOCK_FRAMES - 1)
		: dpll_pkg::ACQ_W'(dpll_pkg::LOCK_FRAMES - 1);
	assign refGood   = tif.valid[refSel_reg] & ~tif.oor[refSel_reg]; // R1
	assign tif.refIn = refIn_reg;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			refIn_reg <= 2'h0;
		end else begin
			refIn_reg <= {secondaryRefInput, primaryRefInput};
		end
	end

	// select levels only change at the frame boundary, not mid frame
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			refSel_reg <= 1'b0;
			pcc_reg    <= 1'b0;
		end else if (tif.frameTick) begin
			refSel_reg <= refSelNow; // R2
			pcc_reg    <= phaseContinuityCtl; // R11
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			frame8kTick <= 1'b0;
		end else begin
			frame8kTick <= tif.frameTick; // R18
		end
	end

	// loop state, evaluated once per frame
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			dpll_pkg::ST_FREERUN: begin
				if (refGood) begin
					state_next = dpll_pkg::ST_ACQUIRE;
				end
			end
			dpll_pkg::ST_ACQUIRE: begin
				if (!refGood) begin
					state_next = dpll_pkg::ST_FREERUN;
				end else if (acq_reg >= acqTarget) begin
					state_next = dpll_pkg::ST_NORMAL;
				end
			end
			dpll_pkg::ST_NORMAL: begin
				if (!refGood) begin
					state_next = dpll_pkg::ST_HOLDOVER;
				end
			end
			dpll_pkg::ST_HOLDOVER: begin
				if (refGood && pcc_reg) begin
					state_next = dpll_pkg::ST_NORMAL; // R10
				end
			end
			default: begin
				state_next = dpll_pkg::ST_FREERUN;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= dpll_pkg::ST_FREERUN;
			acq_reg   <= '0;
		end else if (tif.frameTick) begin
			state_reg <= state_next;
			if (state_reg == dpll_pkg::ST_ACQUIRE && state_next == dpll_pkg::ST_ACQUIRE) begin
				acq_reg <= acq_reg + 1'b1;
			end else begin
				acq_reg <= '0;
			end
		end
	end

	// clear level is trusted to last long enough, so no width filter here
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			clearN_reg       <= 1'b0;
			tieCorrectEnable <= 1'b0;
			tieOffset_reg    <= '0;
		end else begin
			clearN_reg       <= phaseErrorClearN; // R4
			tieCorrectEnable <= clearN_reg; // R5
			if (!clearN_reg) begin
				tieOffset_reg <= '0; // R3
			end else if (tif.frameTick && state_reg == dpll_pkg::ST_HOLDOVER
				&& state_next == dpll_pkg::ST_NORMAL) begin
				tieOffset_reg <= tif.phase;
			end
		end
	end

	// status outputs
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			holdover            <= 1'b0;
			lock                <= 1'b0;
			primaryOutOfRange   <= 1'b0;
			secondaryOutOfRange <= 1'b0;
		end else begin
			holdover            <= state_reg == dpll_pkg::ST_HOLDOVER; // R8
			lock                <= state_reg == dpll_pkg::ST_NORMAL; // R9
			primaryOutOfRange   <= tif.oor[0]; // R17
			secondaryOutOfRange <= tif.oor[1]; // R13
		end
	end

	// stand-in output clock: mclk/2 full rate, a quarter of that otherwise
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg       <= 2'h0;
			e3Ds3ClockOut <= 1'b0;
			e3Ds3Mode     <= 1'b0;
		end else begin
			div_reg   <= div_reg + 1'b1;
			e3Ds3Mode <= pinMode ? e3Ds3ModePin : ctrl_reg[dpll_pkg::CTRL_E3_MODE_BIT]; // R7
			if (fullRate || div_reg == 2'(dpll_pkg::QUARTER_DIV - 1)) begin
				e3Ds3ClockOut <= ~e3Ds3ClockOut; // R6
			end
		end
	end

	// interrupt events and sticky status
	assign events[dpll_pkg::IRQ_LOCK_GAIN_BIT] = lock & ~lockPrev_reg;
	assign events[dpll_pkg::IRQ_LOCK_LOSS_BIT] = ~lock & lockPrev_reg;
	assign events[dpll_pkg::IRQ_HOLD_BIT]      = holdover & ~holdPrev_reg;
	assign events[dpll_pkg::IRQ_MAIN_OOR_BIT]  = primaryOutOfRange ^ oorPrev_reg[0];
	assign events[dpll_pkg::IRQ_ALT_OOR_BIT]   = secondaryOutOfRange ^ oorPrev_reg[1];

	assign readFire   = s_axi_arvalid & s_axi_arready;
	assign statusRead = readFire
		&& {s_axi_araddr[dpll_pkg::ADDR_W-1:2], 2'h0} == dpll_pkg::IRQ_STATUS_OFS;

	// a new event in the clearing cycle survives the read
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lockPrev_reg  <= 1'b0;
			holdPrev_reg  <= 1'b0;
			oorPrev_reg   <= 2'h0;
			irqStatus_reg <= '0;
			irq           <= 1'b0;
		end else begin
			lockPrev_reg  <= lock;
			holdPrev_reg  <= holdover;
			oorPrev_reg   <= {secondaryOutOfRange, primaryOutOfRange};
			irqStatus_reg <= (statusRead ? '0 : irqStatus_reg) | events;
			irq           <= |(((statusRead ? '0 : irqStatus_reg) | events) & irqMask_reg);
		end
	end

	// write channel
	assign writeFire  = awGot_reg & wGot_reg & ~s_axi_bvalid;
	assign awGot_next = writeFire ? 1'b0 : (awGot_reg | (s_axi_awvalid & s_axi_awready));
	assign wGot_next  = writeFire ? 1'b0 : (wGot_reg | (s_axi_wvalid & s_axi_wready));
	assign writeHit   = awAddr_reg == dpll_pkg::CTRL_OFS || awAddr_reg == dpll_pkg::IRQ_MASK_OFS;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			awGot_reg     <= 1'b0;
			wGot_reg      <= 1'b0;
			awAddr_reg    <= '0;
			wData_reg     <= 32'h0;
			wStrb_reg     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= dpll_pkg::RESP_OKAY;
		end else begin
			awGot_reg     <= awGot_next;
			wGot_reg      <= wGot_next;
			s_axi_awready <= ~awGot_next;
			s_axi_wready  <= ~wGot_next;
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_reg <= {s_axi_awaddr[dpll_pkg::ADDR_W-1:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (writeFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= writeHit ? dpll_pkg::RESP_OKAY : dpll_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg    <= dpll_pkg::CTRL_RESET;
			irqMask_reg <= dpll_pkg::IRQ_MASK_RESET;
		end else if (writeFire && wStrb_reg[0]) begin
			if (awAddr_reg == dpll_pkg::CTRL_OFS) begin
				ctrl_reg <= wData_reg[2:0];
			end
			if (awAddr_reg == dpll_pkg::IRQ_MASK_OFS) begin
				irqMask_reg <= wData_reg[dpll_pkg::IRQ_W-1:0];
			end
		end
	end

	// read channel
	always_comb begin
		readMux = 32'h0;
		readHit = 1'b1;
		case ({s_axi_araddr[dpll_pkg::ADDR_W-1:2], 2'h0})
			dpll_pkg::CTRL_OFS:       readMux[2:0] = ctrl_reg;
			dpll_pkg::STATUS_OFS:     readMux[11:0] = {state_reg, refSel_reg, pinMode,
				tieCorrectEnable, e3Ds3Mode, secondaryOutOfRange, primaryOutOfRange,
				holdover, lock};
			dpll_pkg::IRQ_STATUS_OFS: readMux[dpll_pkg::IRQ_W-1:0] = irqStatus_reg;
			dpll_pkg::IRQ_MASK_OFS:   readMux[dpll_pkg::IRQ_W-1:0] = irqMask_reg;
			dpll_pkg::MAIN_COUNT_OFS: readMux[dpll_pkg::CNT_W-1:0] = tif.count[0];
			dpll_pkg::ALT_COUNT_OFS:  readMux[dpll_pkg::CNT_W-1:0] = tif.count[1];
			dpll_pkg::TIE_OFFSET_OFS: readMux[dpll_pkg::PHASE_W-1:0] = tieOffset_reg;
			default:                  readHit = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= dpll_pkg::RESP_OKAY;
		end else if (readFire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= readMux;
			s_axi_rresp   <= readHit ? dpll_pkg::RESP_OKAY : dpll_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end
endmodule

// File: dpll_ref_select_and_status_properties.sv
// concurrent checks on the ports of the reference select and status block
`timescale 1ns/10ps
module dpll_ref_select_and_status_properties #(
	parameter int FRAME_CYCLES  = dpll_pkg::FRAME_CYCLES,
	parameter int SECOND_CYCLES = dpll_pkg::SECOND_CYCLES
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic phaseErrorClearN,
	input wire logic e3Ds3ModePin,
	input wire logic e3Ds3FullRateSelect,
	input wire logic pinControlModeSelect,
	input wire logic frame8kTick,
	input wire logic e3Ds3ClockOut,
	input wire logic e3Ds3Mode,
	input wire logic holdover,
	input wire logic lock,
	input wire logic primaryOutOfRange,
	input wire logic tieCorrectEnable
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	// gap is only trusted once a first tick has been seen
	int   gap;
	logic seen;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gap <= 0;
			seen <= 1'b0;
		end else if (frame8kTick) begin
			gap <= 0;
			seen <= 1'b1;
		end else begin
			gap <= gap + 1;
		end
	end

	a_frame_tick_period: assert property (frame8kTick && seen |-> gap == FRAME_CYCLES - 1)
		else $error("frame tick spacing wrong");
	a_status_at_tick: assert property ($changed({lock, holdover}) |-> $past(frame8kTick))
		else $error("lock or holdover changed off a frame tick");
	a_clear_disables: assert property ((!phaseErrorClearN)[*4] |-> !tieCorrectEnable)
		else $error("corrector enabled while clear low");
	a_clear_reacts: assert property ($fell(phaseErrorClearN) |-> ##[1:3] !tieCorrectEnable)
		else $error("clear did not reach corrector");
	a_full_rate_toggle: assert property ((pinControlModeSelect && e3Ds3FullRateSelect)[*4]
		|-> e3Ds3ClockOut != $past(e3Ds3ClockOut)) else $error("full rate clock not toggling");
	a_quarter_rate_gap: assert property ((pinControlModeSelect && !e3Ds3FullRateSelect)[*8]
		##0 $changed(e3Ds3ClockOut) |-> $past(e3Ds3ClockOut, 1) == $past(e3Ds3ClockOut, 2)
		&& $past(e3Ds3ClockOut, 2) == $past(e3Ds3ClockOut, 3)
		&& $past(e3Ds3ClockOut, 3) == $past(e3Ds3ClockOut, 4)) else $error("quarter rate wrong");
	a_pin_mode_follow: assert property ((pinControlModeSelect && $stable(e3Ds3ModePin))[*3]
		|-> e3Ds3Mode == e3Ds3ModePin) else $error("mode pin not followed");
	a_range_once_per_gate: assert property ($changed(primaryOutOfRange)
		|=> $stable(primaryOutOfRange)[*8]) else $error("range flag changed between gates");
endmodule

bind dpll_ref_select_and_status dpll_ref_select_and_status_properties #(
	.FRAME_CYCLES(FRAME_CYCLES), .SECOND_CYCLES(SECOND_CYCLES)
) u_props (.mclk, .arst_n, .phaseErrorClearN, .e3Ds3ModePin, .e3Ds3FullRateSelect,
	.pinControlModeSelect, .frame8kTick, .e3Ds3ClockOut, .e3Ds3Mode, .holdover, .lock,
	.primaryOutOfRange, .tieCorrectEnable);

// File: ref_source_model.sv
// free running primary and secondary reference sources
`timescale 1ns/10ps
module ref_source_model #(
	parameter int MAIN_HALF_NS = 50,
	parameter int ALT_HALF_NS  = 100
) (
	output logic primaryRefInput,
	output logic secondaryRefInput
);
	// half periods are whole mclk periods and edges fall on mclk falling edges, so no edge lands on a sampling edge
	initial primaryRefInput = 1'b0;
	initial secondaryRefInput = 1'b0;
	always #(MAIN_HALF_NS) primaryRefInput = ~primaryRefInput;
	always #(ALT_HALF_NS) secondaryRefInput = ~secondaryRefInput;
endmodule

// File: dpll_ref_select_and_status_tb.sv
// self-checking bench for the reference select and status block
`timescale 1ns/10ps
`define CHECK(got, exp) begin numChecks++; if ((got) !== (exp)) begin fails++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end
module dpll_ref_select_and_status_tb;
	typedef struct packed {logic [7:0] addr; logic wr; logic [31:0] data; logic [1:0] resp;} row_t;
	typedef struct packed {logic pin; logic [2:0] ctrl; logic mp; logic fp; logic em;
		logic [7:0] tg;} mode_t;
	row_t rows[11] = '{'{8'h00, 1'b0, 32'h4, 2'h0}, '{8'h0c, 1'b0, 32'h0, 2'h0},
		'{8'h00, 1'b1, 32'h3, 2'h0}, '{8'h00, 1'b0, 32'h3, 2'h0}, '{8'h0c, 1'b1, 32'h1f, 2'h0},
		'{8'h0c, 1'b0, 32'h1f, 2'h0}, '{8'h0c, 1'b1, 32'h0, 2'h0}, '{8'h04, 1'b1, 32'h0, 2'h2},
		'{8'h20, 1'b1, 32'h0, 2'h2}, '{8'h20, 1'b0, 32'h0, 2'h2}, '{8'h00, 1'b1, 32'h4, 2'h0}};
	mode_t modes[4] = '{'{1'b0, 3'h2, 1'b0, 1'b1, 1'b1, 8'h08}, '{1'b0, 3'h4, 1'b1, 1'b0, 1'b0, 8'h20},
		'{1'b1, 3'h4, 1'b1, 1'b0, 1'b1, 8'h08}, '{1'b1, 3'h2, 1'b0, 1'b1, 1'b0, 8'h20}};
	logic mclk = 1'b0, arst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic primaryRefInput, secondaryRefInput, refSourceSelect = 1'b0, phaseErrorClearN = 1'b1;
	logic e3Ds3ModePin = 1'b0, e3Ds3FullRateSelect = 1'b1, phaseContinuityCtl = 1'b0;
	logic fastAcquireRequest = 1'b0, pinControlModeSelect = 1'b0;
	logic frame8kTick, e3Ds3ClockOut, e3Ds3Mode, holdover, lock, irq;
	logic primaryOutOfRange, secondaryOutOfRange, tieCorrectEnable;
	int fails = 0, numChecks = 0, cycles = 0;

	always #12.5 mclk = ~mclk;

	ref_source_model u_refs (.primaryRefInput, .secondaryRefInput);

	dpll_ref_select_and_status #(.FRAME_CYCLES(20), .SECOND_CYCLES(400)) u_dut (.mclk, .arst_n,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .primaryRefInput,
		.secondaryRefInput, .refSourceSelect, .phaseErrorClearN, .e3Ds3ModePin,
		.e3Ds3FullRateSelect, .phaseContinuityCtl, .fastAcquireRequest, .pinControlModeSelect,
		.frame8kTick, .e3Ds3ClockOut, .e3Ds3Mode, .holdover, .lock, .primaryOutOfRange,
		.secondaryOutOfRange, .tieCorrectEnable, .irq);

	task automatic finish_test;
		$display("checks %0d mismatches %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// hang guard, far above the roughly 1100 cycles the tests need
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end

	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wait_tick;
		do @(posedge mclk); while (frame8kTick !== 1'b1);
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  n;
		logic        prev;
		repeat (2) @(posedge mclk);
		`CHECK({s_axi_arready, irq, lock, holdover}, 4'h8)
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		$display("test reset done");
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axi_write(rows[i].addr, rows[i].data, r);
			end else begin
				axi_read(rows[i].addr, d, r);
				`CHECK(d, rows[i].data)
			end
			`CHECK(r, rows[i].resp)
		end
		$display("test registers done");
		foreach (modes[i]) begin
			pinControlModeSelect <= modes[i].pin;
			e3Ds3ModePin <= modes[i].mp;
			e3Ds3FullRateSelect <= modes[i].fp;
			axi_write(8'h00, {29'h0, modes[i].ctrl}, r);
			repeat (4) @(posedge mclk);
			n = 8'h00;
			prev = e3Ds3ClockOut;
			repeat (32) begin
				@(posedge mclk);
				if (e3Ds3ClockOut !== prev) n++;
				prev = e3Ds3ClockOut;
			end
			`CHECK(n, modes[i].tg)
			`CHECK(e3Ds3Mode, modes[i].em)
		end
		$display("test rate and mode done");
		// 12 cycles low is the 300 ns minimum
		phaseErrorClearN <= 1'b0;
		repeat (4) @(posedge mclk);
		`CHECK(tieCorrectEnable, 1'b0)
		repeat (8) @(posedge mclk);
		`CHECK(tieCorrectEnable, 1'b0)
		phaseErrorClearN <= 1'b1;
		repeat (4) @(posedge mclk);
		`CHECK(tieCorrectEnable, 1'b1)
		axi_read(8'h18, d, r);
		`CHECK(d, 32'h0)
		$display("test clear done");
		phaseContinuityCtl <= 1'b1;
		fastAcquireRequest <= 1'b1;
		wait_tick();
		refSourceSelect <= 1'b1;
		axi_read(8'h04, d, r);
		`CHECK(d[7:6], 2'h1)
		wait_tick();
		wait_tick();
		axi_read(8'h04, d, r);
		`CHECK(d[7:6], 2'h3)
		pinControlModeSelect <= 1'b0;
		wait_tick();
		wait_tick();
		axi_read(8'h04, d, r);
		`CHECK(d[7:6], 2'h0)
		$display("test select done");
		while (cycles < 1100) @(posedge mclk);
		axi_read(8'h04, d, r);
		`CHECK({d[11:8], d[3:0]}, 8'h1c)
		`CHECK({primaryOutOfRange, secondaryOutOfRange, irq}, 3'h6)
		axi_read(8'h10, d, r);
		`CHECK(d >= 32'd99 && d <= 32'd101, 1'b1)
		axi_read(8'h14, d, r);
		`CHECK(d >= 32'd49 && d <= 32'd51, 1'b1)
		axi_write(8'h0c, 32'h18, r);
		repeat (3) @(posedge mclk);
		`CHECK(irq, 1'b1)
		axi_read(8'h08, d, r);
		`CHECK(d, 32'h18)
		repeat (3) @(posedge mclk);
		`CHECK(irq, 1'b0)
		$display("test range and interrupt done");
		finish_test();
	end
endmodule
